/* File: hdl/clr_consts.svh */
// constants for the character display register port
// assumes a 100 MHz core clock; included by clr_mem, clr_port and the assertion module
`ifndef CLR_CONSTS_SVH
`define CLR_CONSTS_SVH

// command code field positions
`define CLR_CMD_SET_DISP_BIT 7
`define CLR_CMD_SET_GLYPH_BIT 6
`define CLR_CMD_SHIFT_BIT 4
`define CLR_CMD_SHIFT_DISP_BIT 3
`define CLR_CMD_SHIFT_RIGHT_BIT 2
`define CLR_CMD_ENTRY_BIT 2
`define CLR_CMD_ENTRY_UP_BIT 1
`define CLR_CMD_HOME_BIT 1
// reset values
`define CLR_PTR_RESET 7'h00
`define CLR_STEP_UP_RESET 1'b1
// display memory layout
`define CLR_ROW_LEN 7'h28
`define CLR_ROW2_BASE 7'h40
`define CLR_ROW1_LAST 7'h27
`define CLR_ROW2_LAST 7'h67
`define CLR_DISP_DEPTH 80
`define CLR_GLYPH_DEPTH 64
`define CLR_SHIFT_LAST 6'h27
// timing: internal operation length
`define CLR_CLK_MHZ 100
`define CLR_OP_TIME_NS 37000
`define CLR_OP_CYCLES ((`CLR_OP_TIME_NS * `CLR_CLK_MHZ + 999) / 1000)

`endif

/* File: hdl/clr_mem.sv */
// character display memory and custom glyph memory, flip-flop storage
// assumes addresses already wrapped to legal values by the controller
`timescale 1ns/10ps
`include "clr_consts.svh"
module clr_mem
  import clr_pkg::*;
(
  input wire logic core_clk,
  clr_mem_if.mem m
);
  logic [7:0] disp_mem [0:`CLR_DISP_DEPTH-1];
  logic [7:0] glyph_mem [0:`CLR_GLYPH_DEPTH-1];
  logic [6:0] disp_idx;
  logic [6:0] scan_addr;
  logic [6:0] scan_col_sum;
  logic [6:0] scan_idx;

  // second row packed behind the first; unshown cells stay plain storage
  assign disp_idx = (m.addr >= `CLR_ROW2_BASE) ?
    7'(m.addr - `CLR_ROW2_BASE + `CLR_ROW_LEN) : m.addr;

  // host side read
  assign m.rd_data = m.sel_glyph ? glyph_mem[m.addr[5:0]] : disp_mem[disp_idx];

  // host side write
  always_ff @(posedge core_clk)
  begin
    if (m.wr_en)
    begin
      if (m.sel_glyph)
        glyph_mem[m.addr[5:0]] <= m.wr_data;
      else
        disp_mem[disp_idx] <= m.wr_data;
    end
  end

  // screen position to address: column plus shift, modulo row length
  assign scan_col_sum = 7'({4'h0, m.scan_col}) + 7'({1'b0, m.scan_shift});
  assign scan_addr = (scan_col_sum >= `CLR_ROW_LEN) ?
    7'(scan_col_sum - `CLR_ROW_LEN) : scan_col_sum;
  assign scan_idx = m.scan_row ? 7'(scan_addr + `CLR_ROW_LEN) : scan_addr;

  // registered character code for the display scan
  always_ff @(posedge core_clk)
  begin
    m.scan_code <= disp_mem[scan_idx];
  end
endmodule : clr_mem

/* File: hdl/clr_mem_if.sv */
// link between the port control logic and the display memories
// assumes one core clock shared by both ends
`timescale 1ns/10ps
interface clr_mem_if;
  logic sel_glyph;
  logic [6:0] addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic scan_row;
  logic [2:0] scan_col;
  logic [5:0] scan_shift;
  logic [7:0] scan_code;
  modport ctl
  (
    output sel_glyph, addr, wr_en, wr_data, scan_row, scan_col, scan_shift,
    input rd_data, scan_code
  );
  modport mem
  (
    input sel_glyph, addr, wr_en, wr_data, scan_row, scan_col, scan_shift,
    output rd_data, scan_code
  );
endinterface : clr_mem_if

/* File: hdl/clr_pkg.sv */
// types shared by the character display register port modules
// assumes clr_consts.svh for numeric constants
package clr_pkg;
  // internal operation sequencer states
  typedef enum logic [1:0]
  {
    CLR_IDLE = 2'b00,
    CLR_FETCH = 2'b01,
    CLR_WAIT = 2'b10
  } clr_state_t;
endpackage : clr_pkg

/* File: hdl/clr_port.sv */
// host register port of a character display controller, 6800 style bus
// assumes bus pins are asynchronous to core_clk; data pin split in/out/oe
//
// Overview of operation
// - two 8-bit latches, chosen by register_select
// - write-only command latch takes commands and addresses
// - data writes copied into selected memory
// - address command prefetches addressed byte
// - data read prefetches byte at next address
// - select and direction decode four access kinds
// - busy held during internal operation, commands ignored
// - status read: busy on bit7, pointer below
// - address command loads pointer and picks memory
// - pointer steps by one per memory access
// - eighty display cells, unshown ones are storage
// - display address seven bits, both directions
// - unshifted rows start at 00H and 40H
// - left shift moves rows to 01H, 41H
// - write data taken at enable falling edge
// - read data driven while enable high, delayed three clocks
`timescale 1ns/10ps
`include "clr_consts.svh"
module clr_port
  import clr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic enable_strobe,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe,
  output logic internal_op_flag,
  input wire logic scan_row,
  input wire logic [2:0] scan_col,
  output logic [7:0] scan_code
);
  localparam logic [11:0] OP_LAST = 12'(`CLR_OP_CYCLES - 1);

  clr_mem_if mif();
  clr_state_t state_q;
  logic [1:0] rs_sync_q, rw_sync_q, en_sync_q;
  logic [7:0] db_sync1_q, db_sync2_q;
  logic en_prev_q;
  logic [7:0] command_latch_q;
  logic [7:0] data_transfer_latch_q;
  logic [6:0] address_pointer_q;
  logic sel_glyph_q;
  logic step_up_q;
  logic [5:0] shift_q;
  logic [11:0] op_cnt_q;
  logic wr_pulse_q;
  logic en_fall, cmd_wr, data_wr, data_rd;

  // step pointer by one, wrapping per selected memory
  function automatic logic [6:0] clr_step(input logic [6:0] p, input logic up,
                                          input logic glyph);
    logic [6:0] r;
    r = up ? 7'(p + 7'h01) : 7'(p - 7'h01);
    if (glyph)
      r = {1'b0, r[5:0]};
    else if (up && p == `CLR_ROW1_LAST)
      r = `CLR_ROW2_BASE;
    else if (up && p == `CLR_ROW2_LAST)
      r = 7'h00;
    else if (!up && p == 7'h00)
      r = `CLR_ROW2_LAST;
    else if (!up && p == `CLR_ROW2_BASE)
      r = `CLR_ROW1_LAST;
    return r;
  endfunction : clr_step

  // two-flop synchronisers on every bus pin
  always_ff @(posedge core_clk)
  begin
    rs_sync_q <= {rs_sync_q[0], register_select};
    rw_sync_q <= {rw_sync_q[0], read_not_write};
    en_sync_q <= {en_sync_q[0], enable_strobe};
    db_sync1_q <= db_in;
    db_sync2_q <= db_sync1_q;
    en_prev_q <= en_sync_q[1];
  end

  // access decode at the enable falling edge
  assign en_fall = en_prev_q && !en_sync_q[1];
  assign cmd_wr = en_fall && !rs_sync_q[1] && !rw_sync_q[1];
  assign data_wr = en_fall && rs_sync_q[1] && !rw_sync_q[1];
  assign data_rd = en_fall && rs_sync_q[1] && rw_sync_q[1];

  // operation sequencer and busy timer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= CLR_IDLE;
      op_cnt_q <= 12'h000;
    end
    else
    begin
      unique case (state_q)
        CLR_IDLE:
          if (cmd_wr || data_wr || data_rd)
            state_q <= CLR_FETCH;
        CLR_FETCH:
        begin
          state_q <= CLR_WAIT;
          op_cnt_q <= 12'h000;
        end
        CLR_WAIT:
          if (op_cnt_q == OP_LAST)
            state_q <= CLR_IDLE;
          else
            op_cnt_q <= op_cnt_q + 12'h001;
        default:
          state_q <= CLR_IDLE;
      endcase
    end
  end

  // busy flag follows the sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
      internal_op_flag <= 1'b0;
    else
      internal_op_flag <= (state_q != CLR_IDLE) || cmd_wr || data_wr || data_rd;
  end

  // command latch, pointer, memory select, entry and shift settings
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      command_latch_q <= 8'h00;
      address_pointer_q <= `CLR_PTR_RESET;
      sel_glyph_q <= 1'b0;
      step_up_q <= `CLR_STEP_UP_RESET;
      shift_q <= 6'h00;
    end
    else if (state_q == CLR_IDLE && cmd_wr)
    begin
      command_latch_q <= db_sync2_q;
      if (db_sync2_q[`CLR_CMD_SET_DISP_BIT])
      begin
        address_pointer_q <= db_sync2_q[6:0];
        sel_glyph_q <= 1'b0;
      end
      else if (db_sync2_q[`CLR_CMD_SET_GLYPH_BIT])
      begin
        address_pointer_q <= {1'b0, db_sync2_q[5:0]};
        sel_glyph_q <= 1'b1;
      end
      else if (db_sync2_q[`CLR_CMD_SHIFT_BIT])
      begin
        if (!db_sync2_q[`CLR_CMD_SHIFT_DISP_BIT])
          address_pointer_q <= clr_step(address_pointer_q,
            db_sync2_q[`CLR_CMD_SHIFT_RIGHT_BIT], sel_glyph_q);
        else if (db_sync2_q[`CLR_CMD_SHIFT_RIGHT_BIT])
          shift_q <= (shift_q == 6'h00) ? `CLR_SHIFT_LAST : shift_q - 6'h01;
        else
          shift_q <= (shift_q == `CLR_SHIFT_LAST) ? 6'h00 : shift_q + 6'h01;
      end
      else if (db_sync2_q[`CLR_CMD_ENTRY_BIT])
        step_up_q <= db_sync2_q[`CLR_CMD_ENTRY_UP_BIT];
      else if (db_sync2_q[`CLR_CMD_HOME_BIT])
      begin
        address_pointer_q <= `CLR_PTR_RESET;
        shift_q <= 6'h00;
      end
    end
    else if (state_q == CLR_IDLE && (data_wr || data_rd))
      address_pointer_q <= clr_step(address_pointer_q, step_up_q, sel_glyph_q);
  end

  // marks a taken data write, so the fetch step keeps the written byte
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wr_pulse_q <= 1'b0;
    else
      wr_pulse_q <= state_q == CLR_IDLE && data_wr;
  end

  // data latch: host writes, and refills from memory after commands and data reads
  always_ff @(posedge core_clk)
  begin
    if (rst)
      data_transfer_latch_q <= 8'h00;
    else if (state_q == CLR_IDLE && data_wr)
      data_transfer_latch_q <= db_sync2_q;
    else if (state_q == CLR_FETCH && wr_pulse_q)
      data_transfer_latch_q <= data_transfer_latch_q;
    else if (state_q == CLR_FETCH)
      data_transfer_latch_q <= mif.rd_data;
  end

  // memory port: write lands at pointer held before the step
  assign mif.sel_glyph = sel_glyph_q;
  assign mif.addr = address_pointer_q;
  assign mif.wr_en = state_q == CLR_IDLE && data_wr;
  assign mif.wr_data = db_sync2_q;
  assign mif.scan_row = scan_row;
  assign mif.scan_col = scan_col;
  assign mif.scan_shift = shift_q;
  assign scan_code = mif.scan_code;

  // read data and drive enable, following enable high three clocks late
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      db_out <= 8'h00;
      db_oe <= 1'b0;
    end
    else
    begin
      db_oe <= en_sync_q[1] && rw_sync_q[1];
      db_out <= rs_sync_q[1] ? data_transfer_latch_q :
        {internal_op_flag, address_pointer_q};
    end
  end

  clr_mem u_mem
  (
    .core_clk(core_clk),
    .m(mif.mem)
  );
endmodule : clr_port

/* File: verif/char_lcd_host_register_port_tb_top.sv */
// self-checking bench for the display register port
// assumes clr_port, the host model and the bound checker
`timescale 1ns/10ps
module char_lcd_host_register_port_tb_top
  import clr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic rs, rw, en, oe, busy, srow;
  logic [7:0] dbi, dbo, scode, st;
  logic [2:0] scol;
  logic [31:0] rng = 32'h659d;
  int dm[128];
  int gm[64];
  int ptr, sh, n_fail, n_tests, cyc;
  bit gsel;
  bit up = 1'b1;
  always #5 core_clk = ~core_clk;
  clr_port dut
  (
    .core_clk, .rst, .register_select(rs), .read_not_write(rw), .enable_strobe(en),
    .db_in(dbi), .db_out(dbo), .db_oe(oe), .internal_op_flag(busy),
    .scan_row(srow), .scan_col(scol), .scan_code(scode)
  );
  clr_host_model host
  (
    .core_clk, .register_select(rs), .read_not_write(rw), .enable_strobe(en),
    .db_in(dbi), .db_out(dbo), .db_oe(oe)
  );
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  // model pointer step with row wrap
  function automatic int stp(input int p, input bit u);
    if (gsel) return (p + (u ? 1 : 63)) % 64;
    if (u) return p == 7'h27 ? 7'h40 : p == 7'h67 ? 0 : p + 1;
    return p == 7'h40 ? 7'h27 : p == 0 ? 7'h67 : p - 1;
  endfunction : stp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // command, a refused write and a busy read, then model update
  task automatic cmd(input logic [7:0] c);
    host.acc(1'b0, 1'b0, c, 5, st);
    host.acc(1'b1, 1'b0, 8'hee, 5, st);
    host.acc(1'b0, 1'b1, 8'h00, 5, st);
    chk(st & 8'h80, 8'h80);
    host.wait_ready(st);
    gsel = c[7] ? 1'b0 : c[6] ? 1'b1 : gsel;
    ptr = c[7] ? int'(c[6:0]) : c[6] ? int'(c[5:0]) : ptr;
    if (c[7:3] == 5'h03) sh = (sh + (c[2] ? 39 : 1)) % 40;
    if (c[7:3] == 5'h02) ptr = stp(ptr, c[2]);
    if (c[7:2] == 6'h01) up = c[1];
    if (c[7:1] == 7'h01)
    begin
      ptr = 0;
      sh = 0;
    end
    chk(st, 8'(ptr));
  endtask : cmd
  // random data write, then model store and step
  task automatic dwr();
    rng = xs(rng);
    host.acc(1'b1, 1'b0, rng[7:0], 5, st);
    if (gsel) gm[ptr] = rng[7:0];
    else dm[ptr] = rng[7:0];
    host.wait_ready(st);
    ptr = stp(ptr, up);
    chk(st, 8'(ptr));
  endtask : dwr
  task automatic drd(input int hi);
    logic [7:0] rd;
    host.acc(1'b1, 1'b1, 8'h00, hi, rd);
    chk(rd, 8'(gsel ? gm[ptr] : dm[ptr]));
    host.wait_ready(st);
    ptr = stp(ptr, up);
    chk(st, 8'(ptr));
  endtask : drd
  task automatic scan(input int r, input int c);
    @(posedge core_clk);
    srow <= r[0];
    scol <= c[2:0];
    @(posedge core_clk);
    #1 chk(scode, 8'(dm[r * 64 + (c + sh) % 40]));
  endtask : scan
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // main sequence: wraps, prefetch, glyph memory, shifted screen
  initial
  begin
    srow = 1'b0;
    scol = 3'h0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    host.acc(1'b0, 1'b1, 8'h00, 5, st);
    chk(st, 8'h00);
    cmd(8'ha7);
    repeat (4) dwr();
    cmd(8'h04);
    cmd(8'hc2);
    for (int i = 0; i < 4; i++) drd(5 + 4 * i);
    cmd(8'h82);
    repeat (4) dwr();
    cmd(8'h40);
    repeat (2) dwr();
    cmd(8'h40);
    drd(5);
    cmd(8'h10);
    for (int k = 0; k < 4; k++)
    begin
      if (k > 0) cmd(k == 1 ? 8'h18 : k == 2 ? 8'h02 : 8'h1c);
      for (int j = 0; j < 4; j++) scan(j / 2, j % 2);
    end
    end_of_test();
  end
endmodule : char_lcd_host_register_port_tb_top

/* File: verif/clr_host_model.sv */
// host processor model driving the display port pins
// assumes the bench calls its tasks; pins change only after clock edges
`timescale 1ns/10ps
module clr_host_model
  import clr_pkg::*;
(
  input wire logic core_clk,
  output logic register_select,
  output logic read_not_write,
  output logic enable_strobe,
  output logic [7:0] db_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe
);
  // idle bus: strobe low, read selected
  initial
  begin
    register_select = 1'b0;
    read_not_write = 1'b1;
    enable_strobe = 1'b0;
    db_in = 8'h5a;
  end
  // one bus cycle; hi is the strobe high time in cycles
  task automatic acc(input logic rs, input logic rw, input logic [7:0] wd, input int hi,
    output logic [7:0] rd);
    rd = 8'hxx;
    @(posedge core_clk);
    register_select <= rs;
    read_not_write <= rw;
    db_in <= rw ? ~db_in : wd;
    @(posedge core_clk);
    enable_strobe <= 1'b1;
    repeat (hi) @(posedge core_clk);
    if (db_oe === 1'b1) rd = db_out;
    enable_strobe <= 1'b0;
    repeat (5) @(posedge core_clk);
    db_in <= ~db_in;
  endtask : acc
  // poll status until the busy bit clears
  task automatic wait_ready(output logic [7:0] st);
    int n;
    n = 0;
    st = 8'hff;
    while (st[7] !== 1'b0 && n < 600)
    begin
      acc(1'b0, 1'b1, 8'h00, 5, st);
      n++;
    end
  endtask : wait_ready
endmodule : clr_host_model

/* File: verif/clr_port_assertions.sv */
// pin-level checks for the display register port, bound into clr_port
// assumes one core clock and synchronous active-high rst
`timescale 1ns/10ps
`include "clr_consts.svh"
module clr_port_assertions
  import clr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic enable_strobe,
  input wire logic [7:0] db_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  input wire logic internal_op_flag,
  input wire logic scan_row,
  input wire logic [2:0] scan_col,
  input wire logic [7:0] scan_code
);
  logic [12:0] busy_n_q;
  wire rd_en = enable_strobe & read_not_write;
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // length of the current busy stretch
  always_ff @(posedge core_clk)
  begin
    busy_n_q <= (rst || !internal_op_flag) ? 13'h0000 : busy_n_q + 13'h0001;
  end
  chk_oe_on_read: assert property
    (db_oe |-> $past(rd_en, 2) || $past(rd_en, 3) || $past(rd_en, 4))
    else $error("data driven without a read strobe");
  chk_oe_idle_off: assert property ((!enable_strobe)[*5] |-> !db_oe)
    else $error("data still driven after strobe low");
  chk_busy_bit7: assert property
    (db_oe && !$past(register_select, 3) && busy_n_q > 13'h0010 |-> db_out[7])
    else $error("status read hides busy");
  chk_busy_starts: assert property
    ($fell(enable_strobe) && !read_not_write && !internal_op_flag |-> ##[2:6] internal_op_flag)
    else $error("accepted write did not raise busy");
  chk_busy_holds: assert property ($rose(internal_op_flag) |-> internal_op_flag[*8])
    else $error("busy dropped early");
  chk_busy_length: assert property ($fell(internal_op_flag) |->
    int'(busy_n_q) >= `CLR_OP_CYCLES - 2 && int'(busy_n_q) <= `CLR_OP_CYCLES + 6)
    else $error("busy length off");
  chk_status_quiet: assert property
    ($fell(enable_strobe) && read_not_write && !register_select && !internal_op_flag
     |-> (!internal_op_flag)[*6])
    else $error("status read started an operation");
  chk_reset_idle: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |=> !db_oe && !internal_op_flag && db_out == 8'h00)
    else $error("outputs not idle in reset");
  cover property ($rose(internal_op_flag));
  cover property (db_oe && register_select);
  cover property (db_oe && !register_select && internal_op_flag);
endmodule : clr_port_assertions

bind clr_port clr_port_assertions u_chk
(
  .core_clk, .rst, .register_select, .read_not_write, .enable_strobe, .db_in,
  .db_out, .db_oe, .internal_op_flag, .scan_row, .scan_col, .scan_code
);
